// ==== logic/skd_pkg.sv ====
`default_nettype none
package skd_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INSTR = 8'h04;
	localparam logic [7:0] ADDR_PC = 8'h08;
	localparam logic [7:0] ADDR_ACC = 8'h0c;
	localparam logic [7:0] ADDR_MEM = 8'h10;
	localparam logic [7:0] ADDR_FMASK = 8'h14;
	localparam logic [7:0] ADDR_SWSEL = 8'h18;
	localparam logic [7:0] ADDR_IOOUT = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IMG_ACC = 8'h24;
	localparam logic [7:0] ADDR_IMG_PC = 8'h28;
	localparam logic [7:0] ADDR_EADDR = 8'h2c;
	localparam logic [7:0] ADDR_SWITCH = 8'h30;
	localparam logic [7:0] ADDR_BANK = 8'h40;
	localparam logic [5:0] BANK_HI = 6'h10;
	localparam int CTRL_START_BIT = 0;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Opcode digits
	localparam logic [3:0] DG_0 = 4'h0;
	localparam logic [3:0] DG_1 = 4'h1;
	localparam logic [3:0] DG_FIELD = 4'h5;
	localparam logic [3:0] DG_FIELD_NZ = 4'h3;
	localparam logic [3:0] DG_EXT = 4'hb;
	localparam logic [3:0] DG_PAR = 4'hc;
	localparam logic [3:0] DG_NOPAR = 4'hd;
	localparam logic [3:0] DG_PROT = 4'he;
	localparam logic [3:0] DG_NOPROT = 4'hb;
	localparam logic [3:0] DG_SWCLR = 4'h9;
	localparam logic [3:0] DG_SRG = 4'h3;
	localparam logic [3:0] DG_SIO = 4'h4;
	localparam logic [3:0] DG_SPS = 4'h5;
	localparam logic [3:0] DG_RAO = 4'hd;
	localparam logic [3:0] DG_SPA = 4'h7;
	localparam logic [1:0] TST_ZERO = 2'h0;
	localparam logic [1:0] TST_NZ = 2'h1;
	localparam logic [1:0] TST_POS = 2'h2;
	localparam logic [1:0] TST_NEG = 2'h3;
	localparam int SIGN_BIT = 15;

	// Timing in ns and derived cycle counts at the pclk rate
	localparam int CLK_MHZ = 200;
	localparam int T_SKIP_NS = 1100;
	localparam int T_SKIP_TAKEN_NS = 1400;
	localparam int T_RAO_NS = 1900;
	localparam int T_SPA_NS = 2100;
	localparam int T_MEMREF_NS = 550;
	localparam int T_EXT_NS = 1100;
	localparam logic [9:0] CYC_SKIP = 10'((T_SKIP_NS * CLK_MHZ) / 1000);
	localparam logic [9:0] CYC_SKIP_TAKEN = 10'((T_SKIP_TAKEN_NS * CLK_MHZ) / 1000);
	localparam logic [9:0] CYC_RAO = 10'((T_RAO_NS * CLK_MHZ) / 1000);
	localparam logic [9:0] CYC_SPA = 10'((T_SPA_NS * CLK_MHZ) / 1000);
	localparam logic [9:0] CYC_MEMREF = 10'((T_MEMREF_NS * CLK_MHZ) / 1000);
	localparam logic [9:0] CYC_EXT = 10'((T_EXT_NS * CLK_MHZ) / 1000);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_LOAD = 2'b10,
		ST_EXEC = 2'b11
	} skd_state_type;

	// Pins from the console and memory side
	typedef struct packed {
		logic [15:0] console_sw;
		logic parity_err;
		logic protect_fault;
		logic [15:0] io_in;
		logic [15:0] pos_status;
	} skd_pins_type;

	typedef struct packed {
		logic busy;
		logic skip_taken;
		logic illegal;
		logic mem_written;
	} skd_status_type;
endpackage
`default_nettype wire

// ==== logic/skd_reg_bank.sv ====
`default_nettype none
// Small register bank, read data registered
module skd_reg_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [15:0] rd_data
);
	logic [15:0] mem_ff [4];

	// Write port and registered read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				mem_ff[i] <= 16'h0000;
			end
			rd_data <= 16'h0000;
		end else begin
			if (wr_en) begin
				mem_ff[wr_idx] <= wr_data;
			end
			rd_data <= mem_ff[rd_idx];
		end
	end
endmodule
`default_nettype wire

// ==== logic/skd_decode.sv ====
// Chosen here: the address map and the APB slave port.
`default_nettype none
// Functional notes
// - Digit C skips on parity error, D without
// - Digit E skips on protect fault, B without
// - Digit 9 skips if switch clear; 1.1/1.4us
// - Group 00, digit 0/4/8/C: register zero
// - Group 00, digit 1/5/9/D: register nonzero
// - Group 00, digit 2/6/A/E: register positive
// - Group 00, digit 3/7/B/F: register negative
// - Field test skips when masked field nonzero
// - Leading D: word plus one written back, 1.9us
// - Leading 7: store acc, parity into acc
// - Group 0B0: 3 store, 4 io, 5 position
// - Each memory reference adds 550 ns
module skd_decode
	import skd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire skd_pkg::skd_pins_type pins,
	output logic [15:0] io_out,
	output logic busy
);
	import skd_pkg::*;

	typedef struct packed {
		skd_state_type st;
		logic [15:0] instr;
		logic [15:0] pc;
		logic [15:0] acc;
		logic [15:0] mem;
		logic [15:0] fmask;
		logic [3:0] swsel;
		logic [15:0] io_out;
		logic [15:0] img_acc;
		logic [15:0] img_pc;
		logic [11:0] eaddr;
		logic [9:0] cnt;
		skd_status_type stat;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		skd_pins_type s1;
		skd_pins_type s2;
		skd_pins_type s3;
		skd_pins_type pin;
	} skd_regs_type;

	skd_regs_type r_ff;
	skd_regs_type nxt_r;
	logic [15:0] bank_rd;
	logic bank_wr;
	logic [1:0] bank_rd_idx;
	logic bank_hit;

	// Odd parity of a stored word: one when the bit count is even
	function automatic logic word_parity(input logic [15:0] w);
		word_parity = ~(^w);
	endfunction

	// Register test on one word
	function automatic logic reg_test(input logic [1:0] t, input logic [15:0] w);
		case (t)
			TST_ZERO: reg_test = (w == RST_WORD);
			TST_NZ: reg_test = (w != RST_WORD);
			TST_POS: reg_test = ~w[SIGN_BIT];
			default: reg_test = w[SIGN_BIT];
		endcase
	endfunction

	// Program counter after the instruction
	function automatic logic [15:0] next_pc(input logic [15:0] pc, input logic skip,
			input logic [3:0] sfield);
		if (skip) begin
			next_pc = pc + 16'h0001 + {12'h000, sfield};
		end else begin
			next_pc = pc + 16'h0001;
		end
	endfunction

	assign bank_hit = (paddr[7:4] == ADDR_BANK[7:4]);
	assign bank_wr = psel & penable & pwrite & r_ff.pready & bank_hit;
	// Bus owns the read port while selected; fetch waits for a free cycle
	assign bank_rd_idx = psel ? paddr[3:2] : r_ff.instr[7:6];

	skd_reg_bank u_bank (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(bank_wr),
		.wr_idx(paddr[3:2]),
		.wr_data(pwdata[15:0]),
		.rd_idx(bank_rd_idx),
		.rd_data(bank_rd)
	);

	// Next state: pin sync, decode, execution timer, APB slave
	always_comb begin
		logic [3:0] d3;
		logic [3:0] d2;
		logic [3:0] d1;
		logic [3:0] d0;
		logic skip;
		logic [9:0] cyc;
		logic [15:0] sum;
		d3 = r_ff.instr[15:12];
		d2 = r_ff.instr[11:8];
		d1 = r_ff.instr[7:4];
		d0 = r_ff.instr[3:0];
		skip = 1'b0;
		cyc = CYC_SKIP;
		sum = r_ff.mem + 16'h0001;
		nxt_r = r_ff;

		// Three-stage sync; change taken once stages two and three agree
		nxt_r.s1 = pins;
		nxt_r.s2 = r_ff.s1;
		nxt_r.s3 = r_ff.s2;
		if (r_ff.s2 == r_ff.s3) begin
			nxt_r.pin = r_ff.s3;
		end

		case (r_ff.st)
			ST_IDLE: begin
				nxt_r.stat.busy = 1'b0;
			end
			ST_FETCH: begin
				if (!psel) begin
					nxt_r.st = ST_LOAD;
				end
			end
			ST_LOAD: begin
				nxt_r.stat.illegal = 1'b0;
				nxt_r.stat.mem_written = 1'b0;
				nxt_r.eaddr = r_ff.instr[11:0];
				if (d3 == DG_0 && d2 == DG_0) begin
					skip = reg_test(d1[1:0], bank_rd);
				end else if (d3 == DG_0 && d2 == DG_1) begin
					case (d1)
						DG_PAR: skip = r_ff.pin.parity_err;
						DG_NOPAR: skip = ~r_ff.pin.parity_err;
						DG_PROT: skip = r_ff.pin.protect_fault;
						DG_NOPROT: skip = ~r_ff.pin.protect_fault;
						DG_SWCLR: skip = ~r_ff.pin.console_sw[r_ff.swsel];
						default: nxt_r.stat.illegal = 1'b1;
					endcase
				end else if (d3 == DG_0 && d2 == DG_FIELD && d0 == DG_FIELD_NZ) begin
					// Field word is fetched from storage: one memory reference
					skip = ((r_ff.mem & r_ff.fmask) != RST_WORD);
					cyc = CYC_MEMREF;
				end else if (d3 == DG_0 && d2 == DG_EXT && d1 == DG_0) begin
					cyc = CYC_EXT;
					case (d0)
						DG_SRG: begin
							nxt_r.img_acc = r_ff.acc;
							nxt_r.img_pc = r_ff.pc;
						end
						DG_SIO: begin
							nxt_r.io_out = r_ff.acc;
							nxt_r.acc = r_ff.pin.io_in;
						end
						DG_SPS: nxt_r.acc = r_ff.pin.pos_status;
						default: nxt_r.stat.illegal = 1'b1;
					endcase
				end else if (d3 == DG_RAO) begin
					nxt_r.mem = sum;
					nxt_r.stat.mem_written = 1'b1;
					cyc = CYC_RAO + CYC_MEMREF + CYC_MEMREF;
				end else if (d3 == DG_SPA) begin
					nxt_r.mem = r_ff.acc;
					nxt_r.acc = {15'h0000, word_parity(r_ff.acc)};
					nxt_r.stat.mem_written = 1'b1;
					cyc = CYC_SPA + CYC_MEMREF;
				end else begin
					nxt_r.stat.illegal = 1'b1;
				end
				// Skip-class timing: base replaces the default, memory fetch adds on top
				if (d3 == DG_0 && (d2 == DG_0 || d2 == DG_1 || d2 == DG_FIELD)) begin
					if (d2 != DG_FIELD) begin
						cyc = '0;
					end
					if (skip) begin
						cyc = cyc + CYC_SKIP_TAKEN;
					end else begin
						cyc = cyc + CYC_SKIP;
					end
				end
				if (d3 == DG_0 && d2 == DG_FIELD && d0 != DG_FIELD_NZ) begin
					cyc = CYC_SKIP;
				end
				nxt_r.stat.skip_taken = skip;
				nxt_r.pc = next_pc(r_ff.pc, skip, d0);
				// Three cycles outside the count: fetch, load and the final zero-count cycle
				nxt_r.cnt = cyc - 10'd3;
				nxt_r.st = ST_EXEC;
			end
			ST_EXEC: begin
				if (r_ff.cnt == 10'd0) begin
					nxt_r.st = ST_IDLE;
					nxt_r.stat.busy = 1'b0;
				end else begin
					nxt_r.cnt = r_ff.cnt - 10'd1;
				end
			end
			default: nxt_r.st = ST_IDLE;
		endcase

		// APB: one wait state, answer from registers
		nxt_r.pready = 1'b0;
		nxt_r.pslverr = 1'b0;
		if (psel && penable && !r_ff.pready) begin
			nxt_r.pready = 1'b1;
			nxt_r.prdata = 32'h0000_0000;
			case (paddr)
				ADDR_CTRL: nxt_r.prdata = 32'h0000_0000;
				ADDR_INSTR: nxt_r.prdata = {16'h0000, r_ff.instr};
				ADDR_PC: nxt_r.prdata = {16'h0000, r_ff.pc};
				ADDR_ACC: nxt_r.prdata = {16'h0000, r_ff.acc};
				ADDR_MEM: nxt_r.prdata = {16'h0000, r_ff.mem};
				ADDR_FMASK: nxt_r.prdata = {16'h0000, r_ff.fmask};
				ADDR_SWSEL: nxt_r.prdata = {28'h0000000, r_ff.swsel};
				ADDR_IOOUT: nxt_r.prdata = {16'h0000, r_ff.io_out};
				ADDR_STATUS: nxt_r.prdata = {28'h0000000, r_ff.stat};
				ADDR_IMG_ACC: nxt_r.prdata = {16'h0000, r_ff.img_acc};
				ADDR_IMG_PC: nxt_r.prdata = {16'h0000, r_ff.img_pc};
				ADDR_EADDR: nxt_r.prdata = {20'h00000, r_ff.eaddr};
				ADDR_SWITCH: nxt_r.prdata = {16'h0000, r_ff.pin.console_sw};
				default: begin
					if (bank_hit && paddr[1:0] == 2'b00) begin
						nxt_r.prdata = {16'h0000, bank_rd};
					end else begin
						nxt_r.pslverr = 1'b1;
					end
				end
			endcase
		end
		// Writes land on the completing edge; a bus write beats execution
		if (psel && penable && pwrite && r_ff.pready) begin
			case (paddr)
				ADDR_CTRL: begin
					// Start while busy is dropped: one instruction at a time
					if (pwdata[CTRL_START_BIT] && r_ff.st == ST_IDLE) begin
						nxt_r.st = ST_FETCH;
						nxt_r.stat.busy = 1'b1;
					end
				end
				ADDR_INSTR: nxt_r.instr = pwdata[15:0];
				ADDR_PC: nxt_r.pc = pwdata[15:0];
				ADDR_ACC: nxt_r.acc = pwdata[15:0];
				ADDR_MEM: nxt_r.mem = pwdata[15:0];
				ADDR_FMASK: nxt_r.fmask = pwdata[15:0];
				ADDR_SWSEL: nxt_r.swsel = pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Error answer on the write side too
	// Unmapped writes flag pslverr like unmapped reads; read-only writes are dropped without error
	// (handled above: the address case is common to both directions)

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign prdata = r_ff.prdata;
	assign pready = r_ff.pready;
	assign pslverr = r_ff.pslverr;
	assign io_out = r_ff.io_out;
	assign busy = r_ff.stat.busy;
endmodule
`default_nettype wire

// ==== testbench/skd_decode_asserts.sv ====
`default_nettype none
module skd_decode_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] io_out,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	import skd_pkg::*;
	logic [10:0] busy_cnt;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Busy length counter, cleared whenever idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_cnt <= '0;
		else
			busy_cnt <= busy ? busy_cnt + 11'h1 : '0;
	end
	// Bus and start steps
	sequence first_access;
		psel && penable && !$past(penable);
	endsequence
	sequence start_done;
		pready && pwrite && !pslverr && paddr == ADDR_CTRL && pwdata[0];
	endsequence
	chk_one_wait: assert property (first_access |=> pready)
		else $error("ready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	chk_err_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("stray error");
	chk_unmapped_err: assert property (pready && paddr == 8'h34 |-> pslverr)
		else $error("unmapped not refused");
	chk_start_busy: assert property (start_done ##0 !busy |=> busy)
		else $error("start missed");
	chk_busy_cause: assert property ($rose(busy) |-> $past(pready && pwrite && paddr == ADDR_CTRL))
		else $error("busy uncaused");
	chk_busy_len: assert property ($fell(busy) |-> busy_cnt inside {220, 280, 330, 390, 530, 600})
		else $error("bad busy length");
	chk_io_hold: assert property ($changed(io_out) |-> $past(busy))
		else $error("io moved idle");
endmodule
bind skd_decode skd_decode_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .io_out(io_out), .busy(busy));
`default_nettype wire

// ==== testbench/skd_console.sv ====
`default_nettype none
module skd_console (
	input wire logic pclk,
	input wire logic presetn,
	input wire skd_pkg::skd_pins_type want,
	output skd_pkg::skd_pins_type pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import skd_pkg::*;
	// Levels move just after an edge, never mid-cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pins <= '0;
		else
			pins <= want;
	end
endmodule
`default_nettype wire

// ==== testbench/tb_skip_and_misc_opcode_decode.sv ====
`default_nettype none
module tb_skip_and_misc_opcode_decode;
	timeunit 1ns;
	timeprecision 1ps;
	import skd_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, s, busy;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic [15:0] io_out, v;
	logic [3:0] dg [5] = '{4'hc, 4'hd, 4'he, 4'hb, 4'h9};
	skd_pins_type want = '0, pins;
	int bad_count = 0, tests_run = 0, seed = 32'h3caf0ead, k;
	always #2.5 pclk = ~pclk;
	skd_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .io_out(io_out), .busy(busy));
	skd_console far (.pclk(pclk), .presetn(presetn), .want(want), .pins(pins));
	task automatic complete_run();
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== {16'h0, x}) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", nm, x, g);
		end
	endtask
	// One transfer; waits for ready with a bound, idle cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) begin
			bad_count++;
			complete_run();
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Start at pc 100, time busy on the pin so no bus stall, check pc
	task automatic run(input logic [15:0] ins, input logic sk, input int base);
		int t;
		apb(1, ADDR_PC, 16'h100);
		apb(1, ADDR_INSTR, ins);
		apb(1, ADDR_CTRL, 16'h1);
		for (t = 0; busy === 1'b1 && t < 2000; t++)
			@(posedge pclk);
		if (t == 0 || t == 2000) begin
			bad_count++;
			complete_run();
		end
		chk("time", 16'(base + (sk ? 60 : 0)), t);
		apb(0, ADDR_PC, 0);
		chk("pc", 16'h101 + (sk ? 16'(ins[3:0]) : 16'h0), q);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("io_out", 0, io_out);
		// Zero, sign-only and random values against all four tests
		for (k = 0; k < 16; k++) begin
			v = (k < 4) ? 16'h0 : (k < 8) ? 16'h8000 : 16'($random(seed));
			apb(1, ADDR_BANK + 8'(4 * k[3:2]), v);
			case (k[1:0])
				0: s = (v == 0);
				1: s = (v != 0);
				2: s = !v[SIGN_BIT];
				default: s = v[SIGN_BIT];
			endcase
			run({8'h00, 4'(k), 4'h3}, s, 220);
		end
		// Fault flags and switches, random levels each pass
		for (k = 0; k < 10; k++) begin
			want <= 50'({$random(seed), $random(seed)});
			v = 16'($random(seed)) & 16'hf;
			apb(1, ADDR_SWSEL, v);
			repeat (6) @(posedge pclk);
			case (k % 5)
				0: s = want.parity_err;
				1: s = !want.parity_err;
				2: s = want.protect_fault;
				3: s = !want.protect_fault;
				default: s = !want.console_sw[v[3:0]];
			endcase
			run({8'h01, dg[k % 5], 4'h3}, s, 220);
		end
		for (k = 0; k < 6; k++) begin
			v = (k == 0) ? 16'h0 : 16'($random(seed));
			apb(1, ADDR_FMASK, v);
			apb(1, ADDR_MEM, 16'($random(seed)));
			apb(0, ADDR_MEM, 0);
			run({8'h05, 4'(k), 4'h3}, (v & q[15:0]) != 0, 330);
		end
		// Increment wraps at all ones; store keeps odd parity
		for (k = 0; k < 3; k++) begin
			v = (k == 0) ? 16'hffff : 16'($random(seed));
			apb(1, ADDR_MEM, v);
			run(16'hd123, 0, 600);
			apb(0, ADDR_MEM, 0);
			chk("mem_inc", v + 16'h1, q);
			apb(1, ADDR_ACC, v);
			run(16'h7abc, 0, 530);
			apb(0, ADDR_MEM, 0);
			chk("mem_acc", v, q);
			apb(0, ADDR_ACC, 0);
			chk("acc_par", 16'(~^v), q);
		end
		v = 16'($random(seed));
		apb(1, ADDR_ACC, v);
		run(16'h0b03, 0, 220);
		apb(0, ADDR_IMG_ACC, 0);
		chk("img_acc", v, q);
		run(16'h0b04, 0, 220);
		chk("io_out", v, io_out);
		apb(0, ADDR_ACC, 0);
		chk("acc_io", want.io_in, q);
		run(16'h0b05, 0, 220);
		apb(0, ADDR_ACC, 0);
		chk("acc_pos", want.pos_status, q);
		apb(0, 8'h34, 0);
		chk("unmapped", 1, 32'(e));
		complete_run();
	end
endmodule
`default_nettype wire
